// ---- rtl/tcap_pkg.sv ----
/*
  Shared constants of the 16-bit timer with input capture and of its
  controller: byte register map, field positions, reset values, counting
  modes, clock source codes and the controller's word map.
  Assumes nothing of its surroundings.
*/
package tcap_pkg;

  // Byte register map of the timer, index on the 8-bit bus
  localparam int unsigned TCAP_AW     = 4;
  localparam logic [3:0]  REG_CTRL_A  = 4'h0;
  localparam logic [3:0]  REG_CTRL_B  = 4'h1;
  localparam logic [3:0]  REG_CNT_L   = 4'h2;
  localparam logic [3:0]  REG_CNT_H   = 4'h3;
  localparam logic [3:0]  REG_CAP_L   = 4'h4;
  localparam logic [3:0]  REG_CAP_H   = 4'h5;
  localparam logic [3:0]  REG_FLAGS   = 4'h6;
  localparam logic [3:0]  REG_IRQ_EN  = 4'h7;
  localparam logic [3:0]  REG_COMP    = 4'h8;

  // Field positions
  localparam int unsigned CA_MODE_LSB = 0;   // mode bits 1:0
  localparam int unsigned CB_CS_LSB   = 0;   // clock source 2:0
  localparam int unsigned CB_MODE_LSB = 3;   // mode bits 3:2
  localparam int unsigned CB_EDGE_BIT = 6;
  localparam int unsigned CB_FILT_BIT = 7;
  localparam int unsigned FL_OVF_BIT  = 0;
  localparam int unsigned FL_CAP_BIT  = 1;
  localparam int unsigned CMP_SEL_BIT = 2;

  // Reset values
  localparam logic [7:0]  CTRL_RST    = 8'h00;
  localparam logic [15:0] CNT_RST     = 16'h0000;

  // Counting modes
  localparam logic [3:0]  MODE_NORMAL   = 4'h0;
  localparam logic [3:0]  MODE_PC8      = 4'h1;
  localparam logic [3:0]  MODE_PC9      = 4'h2;
  localparam logic [3:0]  MODE_PC10     = 4'h3;
  localparam logic [3:0]  MODE_FAST8    = 4'h5;
  localparam logic [3:0]  MODE_FAST9    = 4'h6;
  localparam logic [3:0]  MODE_FAST10   = 4'h7;
  localparam logic [3:0]  MODE_PFC_CAP  = 4'h8;
  localparam logic [3:0]  MODE_PFC_OCR  = 4'h9;
  localparam logic [3:0]  MODE_PC_CAP   = 4'hA;
  localparam logic [3:0]  MODE_PC_OCR   = 4'hB;
  localparam logic [3:0]  MODE_CTC_CAP  = 4'hC;
  localparam logic [3:0]  MODE_FAST_CAP = 4'hE;
  localparam logic [3:0]  MODE_FAST_OCR = 4'hF;

  localparam logic [15:0] CNT_BOTTOM  = 16'h0000;
  localparam logic [15:0] CNT_MAX     = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT    = 16'h00FF;
  localparam logic [15:0] TOP_9BIT    = 16'h01FF;
  localparam logic [15:0] TOP_10BIT   = 16'h03FF;

  // Clock source codes
  localparam logic [2:0]  CS_STOP     = 3'h0;
  localparam logic [2:0]  CS_DIV1     = 3'h1;
  localparam logic [2:0]  CS_DIV8     = 3'h2;
  localparam logic [2:0]  CS_DIV64    = 3'h3;
  localparam logic [2:0]  CS_DIV256   = 3'h4;
  localparam logic [2:0]  CS_DIV1024  = 3'h5;
  localparam logic [2:0]  CS_EXT_FALL = 3'h6;
  localparam logic [2:0]  CS_EXT_RISE = 3'h7;
  localparam int unsigned PRESC_W     = 10;

  // Controller word map on AHB-Lite, byte registers at index * 4
  localparam logic [7:0]  HOST_BYTE_TOP = 8'h20;
  localparam logic [7:0]  HOST_CNT16    = 8'h40;
  localparam logic [7:0]  HOST_CAP16    = 8'h44;
  localparam logic [7:0]  HOST_SRC      = 8'h48;
  localparam logic [7:0]  HOST_IRQ      = 8'h4C;

endpackage

// ---- rtl/tcap_bus_if.sv ----
/*
  Byte-wide register bus between the timer and its controller, with the
  interrupt requests and their service acknowledges.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface tcap_bus_if;
  import tcap_pkg::*;
  logic [TCAP_AW-1:0] addr;
  logic               wr;
  logic               rd;
  logic [7:0]         wdata;
  logic [7:0]         rdata;
  logic               cap_irq;
  logic               ovf_irq;
  logic               cap_ack;
  logic               ovf_ack;

  modport dev (input  addr, wr, rd, wdata, cap_ack, ovf_ack,
               output rdata, cap_irq, ovf_irq);
  modport cpu (output addr, wr, rd, wdata, cap_ack, ovf_ack,
               input  rdata, cap_irq, ovf_irq);
endinterface

// ---- rtl/tcap_trig.sv ----
/*
  Capture trigger path: two-stage synchronisers on both trigger inputs,
  source select, optional four-sample noise filter and edge detector.
  Assumes the inputs are asynchronous and the controls are on clk_i.
*/
`timescale 1ns/1ps
module tcap_trig
  import tcap_pkg::*;
#(
  parameter int unsigned TAPS = 4
)(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  input  wire logic comp_i,
  input  wire logic sel_comp_i,
  input  wire logic filt_en_i,
  input  wire logic rise_i,
  input  wire logic en_i,
  output logic      edge_o
);
  logic [1:0]      pin_sync_ff;
  logic [1:0]      comp_sync_ff;
  logic [TAPS-2:0] samp_ff;
  logic            filt_ff;
  logic            prev_ff;
  logic            src;
  logic            level;

  // [R16]
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      pin_sync_ff  <= 2'h0;
      comp_sync_ff <= 2'h0;
    end
    else
    begin
      pin_sync_ff  <= {pin_sync_ff[0], pin_i};
      comp_sync_ff <= {comp_sync_ff[0], comp_i};
    end

  assign src = sel_comp_i ? comp_sync_ff[1] : pin_sync_ff[1]; // [R14]

  // Filter samples every system clock, prescaler plays no part
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      samp_ff <= '0;
    else
      samp_ff <= {samp_ff[TAPS-3:0], src}; // [R20]

  // Live sample plus stored ones, so the filter adds exactly TAPS cycles
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      filt_ff <= 1'b0;
    else if (&{samp_ff, src})
      filt_ff <= 1'b1; // [R19]
    else if (~|{samp_ff, src})
      filt_ff <= 1'b0; // [R19]

  assign level = filt_en_i ? filt_ff : src; // [R16]

  // Source switch is seen as a level change here as well
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      prev_ff <= 1'b0;
    else
      prev_ff <= level; // [R15]

  assign edge_o = en_i & (rise_i ? (level & ~prev_ff)
                                 : (~level & prev_ff)); // [R24] [R17]
endmodule

// ---- rtl/tcap_timer.sv ----
/*
  16-bit up/down timer with input capture, byte register bus with a
  shared high-byte staging register, overflow and capture flags.
  Assumes the bus strobes are one-cycle pulses on clk_i and that pins
  come from outside the clock domain.
*/
// Design decisions made here: the address map and the AHB-Lite slave port.
// How it works
// R1: Software may reuse staged high byte
// R2: Clock select zero stops the counter
// R3: Counter clears, counts up or down
// R4: Low byte access moves high byte
// R5: Counter accessible whether running or not
// R6: CPU write beats counting same cycle
// R7: Four-bit mode selects counting sequence
// R8: Overflow flag set per mode
// R9: Trigger edge copies counter to capture
// R10: Capture flag set with copy; irq
// R11: Flag cleared by service or one
// R12: Capture read low byte first
// R13: Capture writable only in capture-top modes
// R14: Comparator select switches trigger source
// R15: Source switch may capture; clear flag; a filtered switch capture lands after the controller's clear
// R16: Triggers synchronised; filter adds four cycles
// R17: Captures suppressed in capture-top modes
// R18: Port-driven pin captures like edge
// R19: Filter output needs four equal samples
// R20: Filter enable bit, system clock only
// R21: New capture overwrites unread value
// R22: Software reverses edge, clears flag
// R23: Zero, max and mode top values
// R24: Edge select picks rising or falling
`timescale 1ns/1ps
module tcap_timer
  import tcap_pkg::*;
#(
  parameter int unsigned FILT_TAPS = 4
)(
  input  wire logic clk_i,
  input  wire logic rst_i,
  tcap_bus_if.dev   bus,
  input  wire logic capture_pin_i,
  input  wire logic comparator_output_i,
  input  wire logic external_count_pin_i,
  output logic      top_o,
  output logic      bottom_o
);
  logic [1:0]        ctrl_a_ff;
  logic [7:0]        ctrl_b_ff;
  logic [7:0]        comp_ff;
  logic [1:0]        irq_en_ff;
  logic [15:0]       cnt_ff;
  logic [15:0]       cap_ff;
  logic [7:0]        temp_ff;
  logic [7:0]        rdata_ff;
  logic              dir_down_ff;
  logic              ovf_ff;
  logic              capf_ff;
  logic              cap_irq_ff;
  logic              ovf_irq_ff;
  logic              top_ff;
  logic              bottom_ff;
  logic [PRESC_W-1:0] presc_ff;
  logic [2:0]        ext_ff;
  logic [3:0]        mode;
  logic [2:0]        cs;
  logic              tick;
  logic              dual;
  logic              fast;
  logic              cap_top;
  logic [15:0]       top;
  logic              trig;
  logic              wr_cnt;
  logic              wr_cap;
  logic              ovf_set;
  logic              ovf_clr;
  logic              cap_clr;
  logic [15:0]       nxt_cnt;
  logic              nxt_dir;
  logic [1:0]        nxt_irq_en;

  assign mode = {ctrl_b_ff[CB_MODE_LSB+1:CB_MODE_LSB], ctrl_a_ff}; // [R7]
  assign cs   = ctrl_b_ff[CB_CS_LSB+2:CB_CS_LSB];

  // Mode decode and top value; compare-A top modes fall back to MAX
  always_comb
  begin
    dual    = 1'b0;
    fast    = 1'b0;
    cap_top = 1'b0;
    top     = CNT_MAX; // [R23]
    case (mode)
      MODE_PC8:      begin dual = 1'b1; top = TOP_8BIT;  end
      MODE_PC9:      begin dual = 1'b1; top = TOP_9BIT;  end
      MODE_PC10:     begin dual = 1'b1; top = TOP_10BIT; end
      MODE_FAST8:    begin fast = 1'b1; top = TOP_8BIT;  end
      MODE_FAST9:    begin fast = 1'b1; top = TOP_9BIT;  end
      MODE_FAST10:   begin fast = 1'b1; top = TOP_10BIT; end
      MODE_PFC_CAP,
      MODE_PC_CAP:   begin dual = 1'b1; cap_top = 1'b1; top = cap_ff; end
      MODE_PFC_OCR,
      MODE_PC_OCR:   dual = 1'b1;
      MODE_CTC_CAP:  begin cap_top = 1'b1; top = cap_ff; end
      MODE_FAST_CAP: begin fast = 1'b1; cap_top = 1'b1; top = cap_ff; end
      MODE_FAST_OCR: fast = 1'b1;
      default:       top = CNT_MAX;
    endcase
  end

  // Prescaler and external count pin synchroniser
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      presc_ff <= '0;
    else
      presc_ff <= presc_ff + 1'b1;

  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      ext_ff <= 3'h0;
    else
      ext_ff <= {ext_ff[1:0], external_count_pin_i};

  always_comb
    case (cs)
      CS_STOP:     tick = 1'b0; // [R2]
      CS_DIV1:     tick = 1'b1;
      CS_DIV8:     tick = &presc_ff[2:0];
      CS_DIV64:    tick = &presc_ff[5:0];
      CS_DIV256:   tick = &presc_ff[7:0];
      CS_DIV1024:  tick = &presc_ff[9:0];
      CS_EXT_FALL: tick = ext_ff[2] & ~ext_ff[1];
      CS_EXT_RISE: tick = ~ext_ff[2] & ext_ff[1];
      default:     tick = 1'b0;
    endcase

  tcap_trig #(
    .TAPS       (FILT_TAPS)
  ) u_trig (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .pin_i      (capture_pin_i), // [R18]
    .comp_i     (comparator_output_i),
    .sel_comp_i (comp_ff[CMP_SEL_BIT]), // [R14]
    .filt_en_i  (ctrl_b_ff[CB_FILT_BIT]), // [R20]
    .rise_i     (ctrl_b_ff[CB_EDGE_BIT]), // [R24]
    .en_i       (~cap_top), // [R17]
    .edge_o     (trig)
  );

  assign wr_cnt = bus.wr & (bus.addr == REG_CNT_L);
  assign wr_cap = bus.wr & (bus.addr == REG_CAP_L) & cap_top; // [R13]

  // Next count per mode
  always_comb
  begin
    nxt_cnt = cnt_ff;
    nxt_dir = dir_down_ff;
    ovf_set = 1'b0;
    if (tick)
    begin
      if (dual)
      begin
        if (!dir_down_ff && cnt_ff >= top)
        begin
          nxt_dir = 1'b1;
          nxt_cnt = cnt_ff - 1'b1;
        end
        else if (dir_down_ff && cnt_ff == CNT_BOTTOM)
        begin
          nxt_dir = 1'b0;
          nxt_cnt = cnt_ff + 1'b1;
          ovf_set = 1'b1; // [R8]
        end
        else
          nxt_cnt = dir_down_ff ? cnt_ff - 1'b1 : cnt_ff + 1'b1; // [R3]
      end
      else
      begin
        nxt_dir = 1'b0;
        nxt_cnt = (cnt_ff == top) ? CNT_BOTTOM : cnt_ff + 1'b1; // [R3]
        ovf_set = fast ? (cnt_ff == top) : (cnt_ff == CNT_MAX); // [R8]
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      cnt_ff      <= CNT_RST;
      dir_down_ff <= 1'b0;
    end
    else if (wr_cnt)
      cnt_ff <= {temp_ff, bus.wdata}; // [R4] [R5] [R6]
    else
    begin
      cnt_ff      <= nxt_cnt;
      dir_down_ff <= nxt_dir;
    end

  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      cap_ff <= CNT_RST;
    else if (wr_cap)
      cap_ff <= {temp_ff, bus.wdata}; // [R13]
    else if (trig)
      cap_ff <= cnt_ff; // [R9] [R21]

  // Shared high-byte staging register
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      temp_ff <= 8'h00;
    else if (bus.wr && (bus.addr == REG_CNT_H || bus.addr == REG_CAP_H))
      temp_ff <= bus.wdata; // [R4] [R1]
    else if (bus.rd && bus.addr == REG_CNT_L)
      temp_ff <= cnt_ff[15:8]; // [R4]
    else if (bus.rd && bus.addr == REG_CAP_L)
      temp_ff <= cap_ff[15:8]; // [R12]

  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      ctrl_a_ff <= CTRL_RST[1:0];
      ctrl_b_ff <= CTRL_RST;
      comp_ff   <= CTRL_RST;
      irq_en_ff <= CTRL_RST[1:0];
    end
    else if (bus.wr)
      case (bus.addr)
        REG_CTRL_A: ctrl_a_ff <= bus.wdata[CA_MODE_LSB+1:CA_MODE_LSB];
        REG_CTRL_B: ctrl_b_ff <= bus.wdata;
        REG_COMP:   comp_ff   <= bus.wdata;
        REG_IRQ_EN: irq_en_ff <= bus.wdata[1:0];
        default:    ctrl_b_ff <= ctrl_b_ff;
      endcase

  // Flags: hardware set wins over a clear in the same cycle
  assign ovf_clr = bus.ovf_ack | (bus.wr && bus.addr == REG_FLAGS &&
                                  bus.wdata[FL_OVF_BIT]);
  assign cap_clr = bus.cap_ack | (bus.wr && bus.addr == REG_FLAGS &&
                                  bus.wdata[FL_CAP_BIT]); // [R11]

  // Requests follow an enable write at once
  assign nxt_irq_en = (bus.wr && bus.addr == REG_IRQ_EN) ? bus.wdata[1:0]
                                                         : irq_en_ff;

  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      ovf_ff  <= 1'b0;
      capf_ff <= 1'b0;
    end
    else
    begin
      ovf_ff  <= ovf_set | (ovf_ff & ~ovf_clr); // [R8]
      capf_ff <= trig | (capf_ff & ~cap_clr); // [R10] [R11]
    end

  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      cap_irq_ff <= 1'b0;
      ovf_irq_ff <= 1'b0;
    end
    else
    begin
      cap_irq_ff <= (trig | (capf_ff & ~cap_clr)) &
                    nxt_irq_en[FL_CAP_BIT]; // [R10]
      ovf_irq_ff <= (ovf_set | (ovf_ff & ~ovf_clr)) &
                    nxt_irq_en[FL_OVF_BIT]; // [R8]
    end

  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      rdata_ff <= 8'h00;
    else if (bus.rd)
      case (bus.addr)
        REG_CTRL_A: rdata_ff <= {6'h00, ctrl_a_ff};
        REG_CTRL_B: rdata_ff <= ctrl_b_ff;
        REG_CNT_L:  rdata_ff <= cnt_ff[7:0]; // [R5]
        REG_CNT_H,
        REG_CAP_H:  rdata_ff <= temp_ff; // [R4] [R12]
        REG_CAP_L:  rdata_ff <= cap_ff[7:0]; // [R12]
        REG_FLAGS:  rdata_ff <= {6'h00, capf_ff, ovf_ff};
        REG_IRQ_EN: rdata_ff <= {6'h00, irq_en_ff};
        REG_COMP:   rdata_ff <= comp_ff;
        default:    rdata_ff <= 8'h00;
      endcase

  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      top_ff    <= 1'b0;
      bottom_ff <= 1'b0;
    end
    else
    begin
      top_ff    <= (cnt_ff == top); // [R3]
      bottom_ff <= (cnt_ff == CNT_BOTTOM); // [R3] [R23]
    end

  assign bus.rdata   = rdata_ff;
  assign bus.cap_irq = cap_irq_ff;
  assign bus.ovf_irq = ovf_irq_ff;
  assign top_o       = top_ff;
  assign bottom_o    = bottom_ff;
endmodule

// ---- rtl/tcap_ctrl.sv ----
/*
  Controller for the timer: AHB-Lite slave that turns word accesses into
  byte operations on the timer bus, with ordered 16-bit accesses, a
  source switch that clears the capture flag it raises with the filter off, and interrupt service.
  Assumes a single AHB-Lite master, single word transfers.
*/
`timescale 1ns/1ps
module tcap_ctrl
  import tcap_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        hsel_i,
  input  wire logic [7:0]  haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic [31:0]      hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  tcap_bus_if.cpu          bus
);
  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_ISSUE, ST_WAIT,
                            ST_CATCH, ST_FIN} tcap_hst_t;
  tcap_hst_t         st_ff;
  logic [7:0]        a_ff;
  logic              w_ff;
  logic [3:0]        op_a_ff [2];
  logic [7:0]        op_d_ff [2];
  logic              op_w_ff;
  logic              op_last_ff;
  logic              idx_ff;
  logic [15:0]       rd_ff;
  logic [31:0]       hrdata_ff;
  logic              hready_ff;
  logic [3:0]        addr_ff;
  logic              wr_ff;
  logic              rd_s_ff;
  logic [7:0]        wdata_ff;
  logic              cap_ack_ff;
  logic              ovf_ack_ff;

  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      st_ff      <= ST_IDLE;
      a_ff       <= 8'h00;
      w_ff       <= 1'b0;
      op_a_ff    <= '{4'h0, 4'h0};
      op_d_ff    <= '{8'h00, 8'h00};
      op_w_ff    <= 1'b0;
      op_last_ff <= 1'b0;
      idx_ff     <= 1'b0;
      rd_ff      <= 16'h0000;
      hrdata_ff  <= 32'h0000_0000;
      hready_ff  <= 1'b1;
      addr_ff    <= 4'h0;
      wr_ff      <= 1'b0;
      rd_s_ff    <= 1'b0;
      wdata_ff   <= 8'h00;
      cap_ack_ff <= 1'b0;
      ovf_ack_ff <= 1'b0;
    end
    else
    begin
      wr_ff      <= 1'b0;
      rd_s_ff    <= 1'b0;
      cap_ack_ff <= 1'b0;
      ovf_ack_ff <= 1'b0;
      case (st_ff)
        ST_IDLE:
          if (hsel_i && hready_i && htrans_i[1])
          begin
            a_ff      <= haddr_i;
            w_ff      <= hwrite_i;
            hready_ff <= 1'b0;
            st_ff     <= ST_SETUP;
          end
        ST_SETUP:
        begin
          op_w_ff    <= w_ff;
          op_last_ff <= 1'b1;
          idx_ff     <= 1'b0;
          hrdata_ff  <= 32'h0000_0000;
          st_ff      <= ST_ISSUE;
          if (a_ff <= HOST_BYTE_TOP && a_ff[1:0] == 2'h0)
          begin
            op_a_ff[0] <= a_ff[5:2];
            op_d_ff[0] <= hwdata_i[7:0];
          end
          else if (a_ff == HOST_CNT16 || a_ff == HOST_CAP16)
          begin
            op_last_ff <= 1'b0;
            if (w_ff)
            begin
              op_a_ff[0] <= (a_ff == HOST_CNT16) ? REG_CNT_H : REG_CAP_H;
              op_d_ff[0] <= hwdata_i[15:8]; // [R13]
              op_a_ff[1] <= (a_ff == HOST_CNT16) ? REG_CNT_L : REG_CAP_L;
              op_d_ff[1] <= hwdata_i[7:0];
            end
            else
            begin
              op_a_ff[0] <= (a_ff == HOST_CNT16) ? REG_CNT_L : REG_CAP_L;
              op_a_ff[1] <= (a_ff == HOST_CNT16) ? REG_CNT_H : REG_CAP_H;
            end // [R12]
          end
          else if (a_ff == HOST_SRC && w_ff)
          begin
            op_last_ff <= 1'b0;
            op_a_ff[0] <= REG_COMP;
            op_d_ff[0] <= hwdata_i[7:0];
            op_a_ff[1] <= REG_FLAGS;
            op_d_ff[1] <= 8'h01 << FL_CAP_BIT; // [R15]
          end
          else
          begin
            st_ff <= ST_FIN;
            if (a_ff == HOST_IRQ && w_ff)
            begin
              cap_ack_ff <= hwdata_i[FL_CAP_BIT]; // [R11]
              ovf_ack_ff <= hwdata_i[FL_OVF_BIT];
            end
            else if (a_ff == HOST_IRQ)
              hrdata_ff <= {30'h0, bus.cap_irq, bus.ovf_irq};
          end
        end
        ST_ISSUE:
        begin
          addr_ff  <= op_a_ff[idx_ff];
          wdata_ff <= op_d_ff[idx_ff];
          wr_ff    <= op_w_ff;
          rd_s_ff  <= ~op_w_ff;
          st_ff    <= ST_WAIT;
        end
        // Timer acts on the strobe here; its read byte stands after
        ST_WAIT:
          st_ff <= ST_CATCH;
        ST_CATCH:
        begin
          if (idx_ff)
            rd_ff[15:8] <= bus.rdata;
          else
            rd_ff[7:0]  <= bus.rdata;
          if (op_last_ff || idx_ff)
          begin
            hrdata_ff <= {16'h0000, (idx_ff ? bus.rdata : rd_ff[15:8]),
                          (idx_ff ? rd_ff[7:0] : bus.rdata)};
            if (op_last_ff)
              hrdata_ff <= {24'h000000, bus.rdata};
            st_ff <= ST_FIN;
          end
          else
          begin
            idx_ff <= 1'b1;
            st_ff  <= ST_ISSUE;
          end
        end
        ST_FIN:
        begin
          hready_ff <= 1'b1;
          st_ff     <= ST_IDLE;
        end
        default: st_ff <= ST_IDLE;
      endcase
    end

  assign hrdata_o    = hrdata_ff;
  assign hreadyout_o = hready_ff;
  assign hresp_o     = 1'b0;
  assign bus.addr    = addr_ff;
  assign bus.wr      = wr_ff;
  assign bus.rd      = rd_s_ff;
  assign bus.wdata   = wdata_ff;
  assign bus.cap_ack = cap_ack_ff;
  assign bus.ovf_ack = ovf_ack_ff;
endmodule

// ---- tb/tcap_properties.sv ----
/*
  Checks on the byte bus between the timer and its controller.
  Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
module tcap_properties
  import tcap_pkg::*;
(
  input wire logic               clk_i,
  input wire logic               rst_i,
  input wire logic [TCAP_AW-1:0] addr,
  input wire logic               wr,
  input wire logic               rd,
  input wire logic [7:0]         wdata,
  input wire logic [7:0]         rdata,
  input wire logic               cap_irq,
  input wire logic               ovf_irq,
  input wire logic               cap_ack,
  input wire logic               ovf_ack
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_flag_clr;
    wr && addr == REG_FLAGS && wdata[FL_CAP_BIT];
  endsequence

  sequence s_src_wr;
    wr && addr == REG_COMP;
  endsequence

  chk_strobe_excl: assert property (!(wr && rd))
    else $error("write and read strobes together");
  chk_rdata_hold: assert property (!rd |=> $stable(rdata))
    else $error("read data moved without a read");
  chk_cap_hold: assert property (cap_irq && !cap_ack && !(wr &&
    (addr == REG_FLAGS || addr == REG_IRQ_EN)) |=> cap_irq)
    else $error("capture request dropped by itself");
  chk_cap_ack_clr: assert property (cap_ack |=> !cap_irq)
    else $error("service left capture request up");
  chk_w1c_clear: assert property (s_flag_clr |=> !cap_irq)
    else $error("writing one left capture request up");
  chk_irq_gate: assert property (wr && addr == REG_IRQ_EN &&
    !wdata[FL_CAP_BIT] |=> !cap_irq)
    else $error("capture request while disabled");
  chk_ovf_ack_clr: assert property (ovf_ack |=> !ovf_irq)
    else $error("service left overflow request up");
  chk_src_switch: assert property (s_src_wr |-> ##[1:6] s_flag_clr)
    else $error("no flag clear after source switch");
endmodule

// ---- tb/tcap_tb_top.sv ----
/*
  Bench: controller and timer joined by their bus, driven over AHB-Lite.
  Assumes the design under rtl/ and a single word-wide bus master.
*/
`timescale 1ns/1ps
module tcap_tb_top
  import tcap_pkg::*;
;
  logic        clk_i;
  logic        rst_i;
  logic [1:0]  htrans;
  logic [7:0]  haddr;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        cap_pin;
  logic        comp_out;
  logic        ext_pin;
  logic        bottom;
  logic        top;
  logic [31:0] r;
  logic [31:0] c [2];
  int          n_mismatch;
  int          tests_run;
  tcap_bus_if  bus ();

  tcap_ctrl tcap_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(1'h1),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(), .bus(bus));
  tcap_timer #(.FILT_TAPS(4)) tcap_timer_inst (.clk_i(clk_i),
    .rst_i(rst_i), .bus(bus), .capture_pin_i(cap_pin),
    .comparator_output_i(comp_out), .external_count_pin_i(ext_pin),
    .top_o(top), .bottom_o(bottom));
  tcap_properties tcap_properties_inst (.clk_i(clk_i), .rst_i(rst_i),
    .addr(bus.addr), .wr(bus.wr), .rd(bus.rd), .wdata(bus.wdata),
    .rdata(bus.rdata), .cap_irq(bus.cap_irq), .ovf_irq(bus.ovf_irq),
    .cap_ack(bus.cap_ack), .ovf_ack(bus.ovf_ack));

  initial
  begin
    clk_i = 1'h0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One single transfer, entered just after a clock edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk_i); while (hready !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_i); while (hready !== 1'h1);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'h1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'h0, a, 32'h0);
    check(r, exp);
  endtask

  task automatic pin(input logic v, input int n);
    cap_pin <= v;
    repeat (n) @(posedge clk_i);
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    wrap_up();
  end

  initial
  begin
    rst_i = 1'h1;
    htrans = 2'h0;
    haddr = 8'h00;
    hwrite = 1'h0;
    hwdata = 32'h0;
    cap_pin = 1'h0;
    comp_out = 1'h0;
    ext_pin = 1'h0;
    n_mismatch = 0;
    tests_run = 0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'h0;
    repeat (2) @(posedge clk_i);
    check({31'h0, bottom}, 32'h1);
    rdc(8'h04, 32'h0);
    wr(HOST_CNT16, 32'h1234);
    repeat (20) @(posedge clk_i);
    rdc(HOST_CNT16, 32'h1234);
    wr(8'h0C, 32'hAB);
    wr(8'h08, 32'hCD);
    rdc(HOST_CNT16, 32'hABCD);
    wr(8'h08, 32'h11);
    rdc(8'h08, 32'h11);
    rdc(8'h0C, 32'hAB);
    // Overflow in normal mode, then service
    wr(HOST_CNT16, 32'hFFF0);
    wr(8'h04, 32'h1);
    repeat (40) @(posedge clk_i);
    wr(8'h04, 32'h0);
    rdc(8'h18, 32'h1);
    xfer(1'h0, HOST_CNT16, 32'h0);
    check(r >> 8, 32'h0);
    wr(8'h1C, 32'h1);
    rdc(HOST_IRQ, 32'h1);
    wr(HOST_IRQ, 32'h1);
    rdc(8'h18, 32'h0);
    // Counter write while counting
    wr(8'h04, 32'h1);
    wr(HOST_CNT16, 32'h5000);
    wr(8'h04, 32'h0);
    xfer(1'h0, HOST_CNT16, 32'h0);
    check(r >> 4, 32'h500);
    // Five rising edges on the external count pin
    wr(HOST_CNT16, 32'h0);
    wr(8'h04, 32'h7);
    repeat (5)
    begin
      ext_pin <= 1'h1;
      repeat (4) @(posedge clk_i);
      ext_pin <= 1'h0;
      repeat (4) @(posedge clk_i);
    end
    wr(8'h04, 32'h0);
    rdc(HOST_CNT16, 32'h5);
    // Captures on selected edges, overwrite
    wr(HOST_CNT16, 32'h0123);
    wr(8'h04, 32'h40);
    pin(1'h1, 8);
    rdc(HOST_CAP16, 32'h0123);
    rdc(8'h18, 32'h2);
    wr(HOST_CNT16, 32'h0456);
    wr(8'h04, 32'h0);
    pin(1'h0, 8);
    rdc(HOST_CAP16, 32'h0456);
    wr(HOST_CNT16, 32'h0789);
    pin(1'h1, 8);
    rdc(HOST_CAP16, 32'h0456);
    wr(8'h18, 32'h2);
    rdc(8'h18, 32'h0);
    pin(1'h0, 8);
    // Filter adds four cycles to a capture of a running count
    for (int i = 0; i < 2; i++)
    begin
      wr(8'h04, i ? 32'hC1 : 32'h41);
      wr(HOST_CNT16, 32'h0);
      pin(1'h1, 12);
      wr(8'h04, 32'h0);
      xfer(1'h0, HOST_CAP16, 32'h0);
      c[i] = r;
      pin(1'h0, 12);
    end
    check(c[1] - c[0], 32'h4);
    wr(8'h18, 32'h2);
    wr(8'h04, 32'hC0);
    pin(1'h1, 2);
    pin(1'h0, 12);
    rdc(8'h18, 32'h0);
    // Capture-top mode
    wr(8'h04, 32'h58);
    wr(HOST_CAP16, 32'h3344);
    wr(HOST_CNT16, 32'h3344);
    check({31'h0, top}, 32'h1);
    pin(1'h1, 8);
    rdc(HOST_CAP16, 32'h3344);
    rdc(8'h18, 32'h0);
    pin(1'h0, 8);
    wr(8'h04, 32'h40);
    wr(HOST_CAP16, 32'h9999);
    rdc(HOST_CAP16, 32'h3344);
    // Capture interrupt and its service
    wr(8'h1C, 32'h2);
    pin(1'h1, 8);
    rdc(HOST_IRQ, 32'h2);
    wr(8'h1C, 32'h0);
    rdc(HOST_IRQ, 32'h0);
    wr(8'h1C, 32'h2);
    wr(HOST_IRQ, 32'h2);
    rdc(8'h18, 32'h0);
    wr(8'h30, 32'hFF);
    rdc(8'h30, 32'h0);
    // Comparator as trigger source
    wr(HOST_CNT16, 32'h0777);
    wr(HOST_SRC, 32'h4);
    rdc(8'h18, 32'h0);
    comp_out <= 1'h1;
    repeat (8) @(posedge clk_i);
    rdc(HOST_CAP16, 32'h0777);
    wr(HOST_CNT16, 32'h0888);
    pin(1'h0, 8);
    pin(1'h1, 8);
    rdc(HOST_CAP16, 32'h0777);
    wrap_up();
  end
endmodule
